// ==== src/dgsc_top.sv ====
// Top of the dual gain serial control block with its Wishbone slave.
`timescale 1ns/1ns
`default_nettype none
`include "dgsc_params.svh"

// What this block does
// - Select high: each shift clock rise shifts up, serial bit into bit zero, unless an enable rises with it.
// - Select high: enable rise copies shift register into that channel's gain.
// - Counting saturates: no step above 63 or below 0.
// - Gain code is six bits, 0.54 dB per step from zero.
// - Edge rate select low picks fastest outputs, high the slowest.
// - Amplifier enable is active low; high turns both amplifiers off.
// - Select low: shift, and each low-enabled gain steps by the serial bit.
module dgsc_top
  import dgsc_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        link_clk_i,
  input  wire logic        serial_shift_clk_i,
  input  wire logic        serial_bit_in_i,
  input  wire logic        chan1_load_enable_n_i,
  input  wire logic        chan2_load_enable_n_i,
  input  wire logic        gain_mode_select_i,
  input  wire logic        output_edge_rate_select_i,
  input  wire logic        amp_enable_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic [5:0]       chan1_gain_value_o,
  output logic [5:0]       chan2_gain_value_o,
  output logic             programmable_amplifier_on_o,
  output logic             output_edge_rate_slow_o
);
  dgsc_gain_if     gain_bus ();
  dgsc_gain_pair_t live;
  logic            live_valid;
  logic [4:0]      pins;
  logic [1:0]      stat_meta;
  logic [1:0]      stat_s;
  logic [1:0]      ctrl;
  logic [7:0]      update_cnt;
  dgsc_wb_state_t  wb_state;
  logic            wb_req;
  logic            wb_wr;
  logic [2:0]      wb_idx;
  logic [31:0]     next_dat;
  logic [11:0]     db1;
  logic [11:0]     db2;

  // ----------------------------------------------------------------
  // Link-domain logic and crossing
  // ----------------------------------------------------------------
  assign pins[`DGSC_PIN_SCLK] = serial_shift_clk_i;
  assign pins[`DGSC_PIN_DATA] = serial_bit_in_i;
  assign pins[`DGSC_PIN_EN1]  = chan1_load_enable_n_i;
  assign pins[`DGSC_PIN_EN2]  = chan2_load_enable_n_i;
  assign pins[`DGSC_PIN_MODE] = gain_mode_select_i;

  dgsc_serial_core u_core (
    .link_clk_i (link_clk_i),
    .rst_n_i    (rst_n_i),
    .pins_i     (pins),
    .gain_bus   (gain_bus.core)
  );

  dgsc_word_cdc u_cdc (
    .link_clk_i   (link_clk_i),
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .gain_bus     (gain_bus.cdc),
    .word_o       (live),
    .word_valid_o (live_valid)
  );

  // ----------------------------------------------------------------
  // Static pins
  // ----------------------------------------------------------------
  // These pins are quasi-static, but are still double-registered.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_meta <= 2'h0;
      stat_s    <= 2'h0;
    end else begin
      stat_meta <= {amp_enable_n_i, output_edge_rate_select_i};
      stat_s    <= stat_meta;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      output_edge_rate_slow_o <= 1'b0;
    end else begin
      output_edge_rate_slow_o <= stat_s[0];
    end
  end

  // Software can force the amplifiers off but never force them on.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      programmable_amplifier_on_o <= 1'b0;
    end else begin
      programmable_amplifier_on_o <= ~stat_s[1] & ~ctrl[`DGSC_CTRL_AMPOFF];
    end
  end

  // ----------------------------------------------------------------
  // Gain outputs
  // ----------------------------------------------------------------
  // Holding freezes the amplifier codes while the link keeps counting.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chan1_gain_value_o <= `DGSC_GAIN_RST;
      chan2_gain_value_o <= `DGSC_GAIN_RST;
    end else if (!ctrl[`DGSC_CTRL_HOLD]) begin
      chan1_gain_value_o <= live.ch1;
      chan2_gain_value_o <= live.ch2;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      update_cnt <= 8'h00;
    end else if (live_valid) begin
      update_cnt <= update_cnt + 8'h01;
    end
  end

  // Gain in hundredths of a dB; the top code reads 34.02 by the linear law.
  assign db1 = 12'(live.ch1) * `DGSC_STEP_CDB;
  assign db2 = 12'(live.ch2) * `DGSC_STEP_CDB;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i & (wb_state == DGSC_WB_IDLE);
  assign wb_wr  = wb_req & wb_we_i;
  assign wb_idx = wb_adr_i[4:2];

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_state <= DGSC_WB_IDLE;
    end else begin
      case (wb_state)
        DGSC_WB_IDLE: begin
          if (wb_req) wb_state <= DGSC_WB_ACK;
        end
        DGSC_WB_ACK: begin
          wb_state <= DGSC_WB_IDLE;
        end
        default: begin
          wb_state <= DGSC_WB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= `DGSC_CTRL_RST;
    end else if (wb_wr && wb_adr_i[7:5] == 3'h0 && wb_idx == `DGSC_IDX_CTRL
                 && wb_sel_i[0]) begin
      ctrl <= wb_dat_i[1:0];
    end
  end

  always_comb begin
    next_dat = 32'h0000_0000;
    if (wb_adr_i[7:5] == 3'h0) begin
      case (wb_idx)
        `DGSC_IDX_CTRL: begin
          next_dat[1:0] = ctrl;
        end
        `DGSC_IDX_GAIN: begin
          next_dat[5:0]  = live.ch1;
          next_dat[13:8] = live.ch2;
        end
        `DGSC_IDX_OUT: begin
          next_dat[5:0]  = chan1_gain_value_o;
          next_dat[13:8] = chan2_gain_value_o;
        end
        `DGSC_IDX_DB1: begin
          next_dat[11:0] = db1;
        end
        `DGSC_IDX_DB2: begin
          next_dat[11:0] = db2;
        end
        `DGSC_IDX_STAT: begin
          next_dat[0]    = stat_s[0];
          next_dat[1]    = stat_s[1];
          next_dat[2]    = programmable_amplifier_on_o;
          next_dat[15:8] = update_cnt;
        end
        default: begin
          next_dat = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= next_dat;
    end
  end
endmodule
`default_nettype wire

// ==== src/dgsc_params.svh ====
// Constants for the dual gain serial control block.
`ifndef DGSC_PARAMS_SVH
`define DGSC_PARAMS_SVH
`define DGSC_GAIN_W      6
`define DGSC_GAIN_MAX    6'h3f
`define DGSC_GAIN_MIN    6'h00
`define DGSC_GAIN_RST    6'h00
`define DGSC_GAIN_ONE    6'h01
`define DGSC_STEP_CDB    12'h036
`define DGSC_IDX_CTRL    3'h0
`define DGSC_IDX_GAIN    3'h1
`define DGSC_IDX_OUT     3'h2
`define DGSC_IDX_DB1     3'h3
`define DGSC_IDX_DB2     3'h4
`define DGSC_IDX_STAT    3'h5
`define DGSC_CTRL_HOLD   0
`define DGSC_CTRL_AMPOFF 1
`define DGSC_CTRL_RST    2'h0
`define DGSC_PIN_SCLK    0
`define DGSC_PIN_DATA    1
`define DGSC_PIN_EN1     2
`define DGSC_PIN_EN2     3
`define DGSC_PIN_MODE    4
`define DGSC_PIN_N       5
`define DGSC_PIN_RST     5'h1f
`endif

// ==== src/dgsc_pkg.sv ====
// Types shared by the dual gain serial control modules.
package dgsc_pkg;
  typedef struct packed {
    logic [5:0] ch2;
    logic [5:0] ch1;
  } dgsc_gain_pair_t;
  typedef enum logic [0:0] {
    DGSC_WB_IDLE = 1'b0,
    DGSC_WB_ACK  = 1'b1
  } dgsc_wb_state_t;
endpackage

// ==== src/dgsc_gain_if.sv ====
// Carrier for the gain codes held in the link domain.
`timescale 1ns/1ns
`default_nettype none
interface dgsc_gain_if;
  import dgsc_pkg::*;
  dgsc_gain_pair_t gains;
  modport core (output gains);
  modport cdc  (input  gains);
endinterface
`default_nettype wire

// ==== src/dgsc_serial_core.sv ====
// Link-domain serial shift register and the two gain registers.
`timescale 1ns/1ns
`default_nettype none
`include "dgsc_params.svh"
module dgsc_serial_core
  import dgsc_pkg::*;
(
  input  wire logic             link_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [4:0]       pins_i,
  dgsc_gain_if.core             gain_bus
);
  logic [1:0] rst_sync;
  logic       link_rst_n;
  logic [4:0] pin_meta;
  logic [4:0] pin_s;
  logic [4:0] pin_d;
  logic [5:0] gain_shift_reg;
  logic [5:0] chan1_gain_value;
  logic [5:0] chan2_gain_value;
  logic       sclk_rise;
  logic       en1_rise;
  logic       en2_rise;
  logic       shifted_bit;
  logic       count_mode;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign link_rst_n = rst_sync[1];

  genvar gi;
  generate
    for (gi = 0; gi < `DGSC_PIN_N; gi++) begin : g_pin
      always_ff @(posedge link_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
          pin_meta[gi] <= 1'b1;
          pin_s[gi]    <= 1'b1;
          pin_d[gi]    <= 1'b1;
        end else begin
          pin_meta[gi] <= pins_i[gi];
          pin_s[gi]    <= pin_meta[gi];
          pin_d[gi]    <= pin_s[gi];
        end
      end
    end
  endgenerate

  assign sclk_rise   = pin_s[`DGSC_PIN_SCLK] & ~pin_d[`DGSC_PIN_SCLK];
  assign en1_rise    = pin_s[`DGSC_PIN_EN1] & ~pin_d[`DGSC_PIN_EN1];
  assign en2_rise    = pin_s[`DGSC_PIN_EN2] & ~pin_d[`DGSC_PIN_EN2];
  assign shifted_bit = pin_s[`DGSC_PIN_DATA];
  assign count_mode  = ~pin_s[`DGSC_PIN_MODE];

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  // With select high, an enable edge seen together with a clock edge counts as a load only.
  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      gain_shift_reg <= `DGSC_GAIN_RST;
    end else if (sclk_rise && (count_mode || !(en1_rise || en2_rise))) begin
      gain_shift_reg <= {gain_shift_reg[4:0], shifted_bit};
    end
  end

  function automatic logic [5:0] step_gain(input logic [5:0] g, input logic up);
    if (up) step_gain = (g == `DGSC_GAIN_MAX) ? g : g + `DGSC_GAIN_ONE;
    else step_gain = (g == `DGSC_GAIN_MIN) ? g : g - `DGSC_GAIN_ONE;
  endfunction

  // ----------------------------------------------------------------
  // Gain registers
  // ----------------------------------------------------------------
  // The controller frames six bits under a low enable before raising it.
  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      chan1_gain_value <= `DGSC_GAIN_RST;
    end else if (!count_mode && en1_rise) begin
      chan1_gain_value <= gain_shift_reg;
    end else if (count_mode && sclk_rise && !pin_s[`DGSC_PIN_EN1]) begin
      chan1_gain_value <= step_gain(chan1_gain_value, shifted_bit);
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      chan2_gain_value <= `DGSC_GAIN_RST;
    end else if (!count_mode && en2_rise) begin
      chan2_gain_value <= gain_shift_reg;
    end else if (count_mode && sclk_rise && !pin_s[`DGSC_PIN_EN2]) begin
      chan2_gain_value <= step_gain(chan2_gain_value, shifted_bit);
    end
  end

  assign gain_bus.gains = '{ch2: chan2_gain_value, ch1: chan1_gain_value};
endmodule
`default_nettype wire

// ==== src/dgsc_word_cdc.sv ====
// Toggle handshake carrying the gain pair from the link to the bus clock.
`timescale 1ns/1ns
`default_nettype none
`include "dgsc_params.svh"
module dgsc_word_cdc
  import dgsc_pkg::*;
(
  input  wire logic             link_clk_i,
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  dgsc_gain_if.cdc              gain_bus,
  output dgsc_gain_pair_t       word_o,
  output logic                  word_valid_o
);
  dgsc_gain_pair_t held;
  logic            req;
  logic [1:0]      ack_sync;
  logic [2:0]      req_sync;
  logic            ack;

  // Source side: a new word is held steady until its toggle returns.
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held     <= '0;
      req      <= 1'b0;
      ack_sync <= 2'h0;
    end else begin
      ack_sync <= {ack_sync[0], ack};
      if ((ack_sync[1] == req) && (gain_bus.gains != held)) begin
        held <= gain_bus.gains;
        req  <= ~req;
      end
    end
  end

  // Destination side.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_sync     <= 3'h0;
      ack          <= 1'b0;
      word_o       <= '0;
      word_valid_o <= 1'b0;
    end else begin
      req_sync     <= {req_sync[1:0], req};
      word_valid_o <= req_sync[2] ^ req_sync[1];
      if (req_sync[2] ^ req_sync[1]) begin
        word_o <= held;
        ack    <= req_sync[1];
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/dgsc_top_assertions.sv ====
// Checker on the ports of the dual gain serial control top.
`timescale 1ns/1ns
`default_nettype none
module dgsc_top_assertions (
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       gain_mode_select_i,
  input wire logic       amp_enable_n_i,
  input wire logic       output_edge_rate_select_i,
  input wire logic [5:0] chan1_gain_value_o,
  input wire logic [5:0] chan2_gain_value_o,
  input wire logic       programmable_amplifier_on_o,
  input wire logic       output_edge_rate_slow_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_in_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  no_stray_ack_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  amp_off_a: assert property (amp_enable_n_i [*5] |-> !programmable_amplifier_on_o)
    else $error("amplifiers on while enable is high");
  slew_slow_a: assert property (output_edge_rate_select_i [*5] |-> output_edge_rate_slow_o)
    else $error("slow edge rate not selected");
  slew_fast_a: assert property ((!output_edge_rate_select_i) [*5] |-> !output_edge_rate_slow_o)
    else $error("fast edge rate not selected");
  no_wrap_one_a: assert property ((!gain_mode_select_i) [*8] |->
    !(chan1_gain_value_o == 6'h00 && $past(chan1_gain_value_o) == 6'h3f) &&
    !(chan1_gain_value_o == 6'h3f && $past(chan1_gain_value_o) == 6'h00))
    else $error("channel one gain wrapped");
  no_wrap_two_a: assert property ((!gain_mode_select_i) [*8] |->
    !(chan2_gain_value_o == 6'h00 && $past(chan2_gain_value_o) == 6'h3f) &&
    !(chan2_gain_value_o == 6'h3f && $past(chan2_gain_value_o) == 6'h00))
    else $error("channel two gain wrapped");
  // Reset is itself the cause here, so this one must not be disabled by it.
  reset_zero_a: assert property (disable iff (1'b0) !rst_n_i |->
    chan1_gain_value_o == 6'h00 && chan2_gain_value_o == 6'h00 && !wb_ack_o)
    else $error("outputs not cleared in reset");
  cover property (wb_ack_o);
  cover property (chan1_gain_value_o == 6'h3f && chan2_gain_value_o == 6'h3f);
  cover property (!programmable_amplifier_on_o && !amp_enable_n_i);
endmodule
bind dgsc_top dgsc_top_assertions u_dgsc_top_assertions (.*);
`default_nettype wire

// ==== sim/dgsc_serial_host.sv ====
// Behavioural controller that drives the serial gain pins.
`timescale 1ns/1ns
`default_nettype none
module dgsc_serial_host (
  input  wire logic ref_clk_i,
  output logic      shift_clk_o,
  output logic      bit_o,
  output logic      en1_n_o,
  output logic      en2_n_o,
  output logic      mode_o
);
  initial begin
    shift_clk_o = 1'b0;
    bit_o = 1'b0;
    en1_n_o = 1'b1;
    en2_n_o = 1'b1;
    mode_o = 1'b1;
  end
  // Every level lasts hw bus cycles, far above the link sampling minimum.
  task automatic pulse(input int hw);
    shift_clk_o <= 1'b1;
    repeat (hw) @(posedge ref_clk_i);
    shift_clk_o <= 1'b0;
    repeat (hw) @(posedge ref_clk_i);
  endtask
  task automatic load(input logic [1:0] ch, input logic [5:0] w, input int hw);
    mode_o <= 1'b1;
    {en2_n_o, en1_n_o} <= ~ch;
    for (int i = 5; i >= 0; i--) begin
      bit_o <= w[i];
      repeat (hw) @(posedge ref_clk_i);
      pulse(hw);
    end
    {en2_n_o, en1_n_o} <= 2'b11;
    bit_o <= ~bit_o;
    repeat (hw) @(posedge ref_clk_i);
  endtask
  task automatic step(input logic [1:0] ch, input logic up, input int n, input int hw);
    mode_o <= 1'b0;
    repeat (hw) @(posedge ref_clk_i);
    {en2_n_o, en1_n_o} <= ~ch;
    bit_o <= up;
    repeat (hw) @(posedge ref_clk_i);
    repeat (n) pulse(hw);
    {en2_n_o, en1_n_o} <= 2'b11;
    repeat (hw) @(posedge ref_clk_i);
    mode_o <= 1'b1;
    repeat (hw) @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// ==== sim/test_dgsc_top.sv ====
// Self-checking bench for the dual gain serial control block.
`timescale 1ns/1ns
`default_nettype none
module test_dgsc_top;
  logic        ref_clk_i = 1'b0;
  logic        link_clk_i = 1'b0;
  logic        rst_n_i = 1'b1;
  logic        edge_sel = 1'b0;
  logic        amp_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [5:0]  g1 = 6'h00;
  logic [5:0]  g2 = 6'h00;
  logic [5:0]  w;
  logic [31:0] exp_q[$];
  int          err_count = 0;
  int          checks = 0;
  int          seed = 82;
  wire logic   sclk, sbit, en1_n, en2_n, gain_mode_select, ack, amp_on, slow;
  wire logic [31:0] rdat;
  wire logic [5:0]  g1_o, g2_o;
  always #50 ref_clk_i = ~ref_clk_i;
  always #3 link_clk_i = ~link_clk_i;
  dgsc_serial_host u_dgsc_serial_host (.ref_clk_i(ref_clk_i), .shift_clk_o(sclk),
    .bit_o(sbit), .en1_n_o(en1_n), .en2_n_o(en2_n), .mode_o(gain_mode_select));
  dgsc_top u_dgsc_top (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
    .serial_shift_clk_i(sclk), .serial_bit_in_i(sbit),
    .chan1_load_enable_n_i(en1_n), .chan2_load_enable_n_i(en2_n),
    .gain_mode_select_i(gain_mode_select), .output_edge_rate_select_i(edge_sel),
    .amp_enable_n_i(amp_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .chan1_gain_value_o(g1_o), .chan2_gain_value_o(g2_o),
    .programmable_amplifier_on_o(amp_on), .output_edge_rate_slow_o(slow));
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic compare(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // Read results are matched in issue order as each read ack appears.
  always @(posedge ref_clk_i) begin
    if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      compare(exp_q.pop_front(), rdat);
  end
  // The request is held until ack is sampled high at a rising edge.
  task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk_i);
    {cyc, stb, we, sel, adr, wdat} <= {2'b11, w_en, 4'hf, a, d};
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) begin
      err_count++;
      stop_test();
    end
    {cyc, stb, we, sel} <= 7'h0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // Twelve bus cycles cover the link to bus handover of a new gain pair.
  task automatic chk_out(input logic sl, input logic on);
    repeat (12) @(posedge ref_clk_i);
    compare({18'h0, sl, on, g2, g1}, {18'h0, slow, amp_on, g2_o, g1_o});
  endtask
  initial begin
    rst_n_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    chk_out(1'b0, 1'b1);
    rd(8'h04, 32'h0);
    wb(1'b1, 8'h18, 32'hffffffff);
    rd(8'h18, 32'h0);
    $display("Test reset done");
    repeat (3) begin
      w = 6'($random(seed));
      u_dgsc_serial_host.load(2'b01, w, 1);
      g1 = w;
      chk_out(1'b0, 1'b1);
      rd(8'h0c, 32'(w) * 32'd54);
    end
    u_dgsc_serial_host.load(2'b11, 6'h3f, 2);
    {g2, g1} = 12'hfff;
    chk_out(1'b0, 1'b1);
    rd(8'h10, 32'd3402);
    u_dgsc_serial_host.step(2'b01, 1'b1, 2, 1);
    chk_out(1'b0, 1'b1);
    u_dgsc_serial_host.load(2'b10, 6'h01, 1);
    u_dgsc_serial_host.step(2'b10, 1'b0, 3, 1);
    g2 = 6'h00;
    chk_out(1'b0, 1'b1);
    u_dgsc_serial_host.step(2'b11, 1'b1, 1, 1);
    g2 = 6'h01;
    chk_out(1'b0, 1'b1);
    wb(1'b1, 8'h04, 32'h0);
    rd(8'h04, {18'h0, g2, 2'b00, g1});
    wb(1'b1, 8'h00, 32'h1);
    u_dgsc_serial_host.step(2'b10, 1'b1, 1, 1);
    chk_out(1'b0, 1'b1);
    rd(8'h04, {18'h0, 6'h02, 2'b00, g1});
    rd(8'h08, {18'h0, g2, 2'b00, g1});
    g2 = 6'h02;
    wb(1'b1, 8'h00, 32'h0);
    chk_out(1'b0, 1'b1);
    $display("Test serial done");
    for (int k = 0; k < 4; k++) begin
      {amp_n, edge_sel} <= 2'(k);
      chk_out(k[0], !k[1]);
    end
    amp_n <= 1'b0;
    wb(1'b1, 8'h00, 32'h2);
    chk_out(1'b1, 1'b0);
    rd(8'h00, 32'h2);
    wb(1'b1, 8'h00, 32'h0);
    chk_out(1'b1, 1'b1);
    $display("Test static pins done");
    stop_test();
  end
endmodule
`default_nettype wire
